/* mdx_defs.vh */
// Purpose: shared constants of the multiply/divide and far addressing card
// Assumes: 16-bit words, 15-bit memory addresses
// Notes: opcode values are written in hex, taken from the octal codes
`ifndef MDX_DEFS_VH
`define MDX_DEFS_VH
// one-word opcode field, instr[15:12]
`define MDX_OP_MUL 4'hE
`define MDX_OP_DIV 4'hF
// two-word group field, instr[15:6]
`define MDX_EXT_G0 10'h030
`define MDX_EXT_G1 10'h031
// group 0 sub-operations, instr[5:3]
`define MDX_G0_LDA 3'h1
`define MDX_G0_LDB 3'h2
`define MDX_G0_LDX 3'h3
`define MDX_G0_INR 3'h4
`define MDX_G0_STA 3'h5
`define MDX_G0_STB 3'h6
`define MDX_G0_STX 3'h7
// group 1 sub-operations, instr[5:3]
`define MDX_G1_OR 3'h1
`define MDX_G1_ADD 3'h2
`define MDX_G1_XOR 3'h3
`define MDX_G1_SUB 3'h4
`define MDX_G1_AND 3'h5
`define MDX_G1_MUL 3'h6
`define MDX_G1_DIV 3'h7
// address mode field, instr[2:0]
`define MDX_MODE_REL 3'h4
`define MDX_MODE_IDX 3'h5
`define MDX_MODE_IDB 3'h6
`define MDX_MODE_IND 3'h7
// word layout
`define MDX_SIGN 15
`define MDX_MOST_NEG 16'h8000
// machine cycles reported per instruction
`define MDX_CYC_ONE_MD 4'hA
`define MDX_CYC_EXT_MD 4'hB
`define MDX_CYC_EXT_LS 4'h3
`define MDX_CYC_EXT_INR 4'h4
// loop ends
`define MDX_MUL_LAST 5'h0F
`define MDX_DIV_LAST 5'h1E
`endif

/* mdx_ea.v */
// Purpose: effective address former for two-word instructions
// Assumes: mode in the low three bits of the first word
// Notes: purely combinational; the core registers the result
`include "mdx_defs.vh"
module mdx_ea (
  // mode and second word
  input wire [2:0] mode,
  input wire [15:0] word2,
  // base registers
  input wire [15:0] p_reg,
  input wire [15:0] x_reg,
  input wire [15:0] b_reg,
  // results
  output reg [14:0] ea,
  output reg imm,
  output reg ind
);
  reg [15:0] sum;
  // mode decode and base add
  always @* begin
    sum = word2;
    imm = 1'b0;
    ind = 1'b0;
    case (mode)
      `MDX_MODE_REL: sum = word2 + p_reg + 16'h0001;
      `MDX_MODE_IDX: sum = word2 + x_reg;
      `MDX_MODE_IDB: sum = word2 + b_reg;
      `MDX_MODE_IND: ind = word2[`MDX_SIGN];
      default: imm = 1'b1;
    endcase
    ea = sum[14:0];
  end
endmodule // mdx_ea

/* mdx_core.v */
// Purpose: multiply, divide and far-address sequencer beside the cpu datapath
// Assumes: host supplies registers at start and serves memory by req/ack
// Notes: results return as register images with write strobes
`include "mdx_defs.vh"
// Operation
// - multiply gives R times B plus A
// - A holds sign, B bit 15 zero
// - positive operands never flag overflow
// - both most negative flags overflow
// - dividend A:B, B sign ignored
// - quotient to B, remainder to A
// - quotient out of range flags overflow
// - zero divisor gives fixed complemented result
// - negative exact multiple gives quotient magnitude minus one
// - far instructions are two words
// - modes 0-3 immediate, no indirect
// - mode 4 adds P plus one
// - mode 5 adds X, 6 adds B
// - mode 7 direct or indirect by bit 15
// - indirect chain followed until bit 15 clear
// - one-word multiply takes ten cycles
// - one-word divide takes ten cycles
// - far loads and stores, three cycles
// - far increment and replace, four cycles
// - far multiply and divide, eleven cycles
// - far add, sub, or, xor, and
// - multiplier lsb picks add, every step shifts
// - count fifteen ends, negative gets correction
module mdx_core (
  // clock and reset
  input wire clk,
  input wire rst,
  // instruction start
  input wire start,
  input wire [15:0] instr,
  input wire [15:0] word2,
  input wire dma_inhibit,
  // cpu register images
  input wire [15:0] a_in,
  input wire [15:0] b_in,
  input wire [15:0] x_in,
  input wire [15:0] p_in,
  // memory cycle port
  output reg mem_req_q,
  output reg mem_we_q,
  output reg [14:0] mem_addr_q,
  output reg [15:0] mem_wdata_q,
  input wire mem_ack,
  input wire [15:0] mem_rdata,
  // results
  output reg [15:0] a_q,
  output reg [15:0] b_q,
  output reg [15:0] x_q,
  output reg a_we_q,
  output reg b_we_q,
  output reg x_we_q,
  output reg ovf_set_q,
  output reg done_q,
  output reg refused_q,
  output reg busy_q,
  output reg [3:0] cycles_q
);
  // one-hot sequencer states
  localparam S_IDLE = 8'h01;
  localparam S_IND = 8'h02;
  localparam S_OPRD = 8'h04;
  localparam S_EXEC = 8'h08;
  localparam S_MUL = 8'h10;
  localparam S_DIV = 8'h20;
  localparam S_DFIN = 8'h40;
  localparam S_WR = 8'h80;

  reg [7:0] state_q; // sequencer state
  reg grp_q; // 0 load/store group, 1 arithmetic group
  reg [2:0] sub_q; // sub-operation
  reg imm_q; // operand came from the second word
  reg [15:0] op_q; // operand, from memory or the second word
  reg [31:0] prod_q; // multiply accumulator
  reg [31:0] mcand_q; // shifted multiplicand
  reg [15:0] mplier_q; // shifting multiplier
  reg [4:0] cnt_q; // step counter for both loops
  reg negative_operand_flag; // multiplier or dividend sign
  reg qneg_q; // quotient sign
  reg mul_ovf_q; // both operands most negative
  reg [30:0] dvd_q; // dividend magnitude, then quotient
  reg [16:0] rm_q; // divisor magnitude, up to 32768
  reg [15:0] rem_q; // partial remainder

  wire [14:0] ea;
  wire ea_imm;
  wire ea_ind;
  wire one_mul = (instr[15:12] == `MDX_OP_MUL);
  wire one_div = (instr[15:12] == `MDX_OP_DIV);
  wire ext_hit = ((instr[15:6] == `MDX_EXT_G0) || (instr[15:6] == `MDX_EXT_G1)) && (instr[5:3] != 3'h0);
  wire st_dec = ~instr[6] & (instr[5:3] >= `MDX_G0_STA);
  // multiply step controls
  wire add_step_flag = mplier_q[0];
  wire last_cycle_flag = (cnt_q == `MDX_MUL_LAST);

  // second word holds base or operand
  mdx_ea u_ea (
    .mode(instr[2:0]),
    .word2(word2),
    .p_reg(p_in),
    .x_reg(x_in),
    .b_reg(b_in),
    .ea(ea),
    .imm(ea_imm),
    .ind(ea_ind)
  );

  // store data picked by sub-operation of the registered op
  reg [15:0] st_data;
  always @* begin
    case (sub_q)
      `MDX_G0_STB: st_data = b_q;
      `MDX_G0_STX: st_data = x_q;
      default: st_data = a_q;
    endcase
  end

  // documented cycle count of the instruction being started
  reg [3:0] cyc_dec;
  always @* begin
    if (one_mul || one_div) begin
      cyc_dec = `MDX_CYC_ONE_MD;
    end else if (instr[6] && instr[5:3] >= `MDX_G1_MUL) begin
      cyc_dec = `MDX_CYC_EXT_MD;
    end else if (!instr[6] && instr[5:3] == `MDX_G0_INR) begin
      cyc_dec = `MDX_CYC_EXT_INR;
    end else begin
      cyc_dec = `MDX_CYC_EXT_LS;
    end
  end

  // arithmetic group sums with overflow
  wire [15:0] sum_w = a_q + op_q;
  wire [15:0] dif_w = a_q - op_q;
  wire add_ovf = (a_q[15] == op_q[15]) && (sum_w[15] != a_q[15]);
  wire sub_ovf = (a_q[15] != op_q[15]) && (dif_w[15] != a_q[15]);

  // divide setup and step terms
  wire [30:0] dvd_raw = {a_q, b_q[14:0]};
  wire [16:0] op_ext = {op_q[15], op_q};
  wire [16:0] div_shift = {rem_q, dvd_q[30]};
  wire div_fit = (div_shift >= rm_q);
  wire [16:0] div_sub = div_shift - rm_q;

  // divide finishing terms
  reg exact;
  reg [30:0] qmag;
  reg [16:0] rmag;
  reg [15:0] q_fin;
  reg [15:0] r_fin;
  reg q_ovf;
  always @* begin
    exact = negative_operand_flag && (rem_q == 16'h0000) && (dvd_q != 31'h00000000);
    qmag = exact ? dvd_q - 31'h00000001 : dvd_q;
    rmag = exact ? rm_q : {1'b0, rem_q};
    q_fin = qneg_q ? 16'h0000 - qmag[15:0] : qmag[15:0];
    r_fin = negative_operand_flag ? 16'h0000 - rmag[15:0] : rmag[15:0];
    q_ovf = qneg_q ? (qmag > 31'h00008000) : (qmag > 31'h00007FFF);
  end

  // main sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      grp_q <= 1'b0;
      sub_q <= 3'h0;
      imm_q <= 1'b0;
      op_q <= 16'h0000;
      prod_q <= 32'h00000000;
      mcand_q <= 32'h00000000;
      mplier_q <= 16'h0000;
      cnt_q <= 5'h00;
      negative_operand_flag <= 1'b0;
      qneg_q <= 1'b0;
      mul_ovf_q <= 1'b0;
      dvd_q <= 31'h00000000;
      rm_q <= 17'h00000;
      rem_q <= 16'h0000;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 15'h0000;
      mem_wdata_q <= 16'h0000;
      a_q <= 16'h0000;
      b_q <= 16'h0000;
      x_q <= 16'h0000;
      a_we_q <= 1'b0;
      b_we_q <= 1'b0;
      x_we_q <= 1'b0;
      ovf_set_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      busy_q <= 1'b0;
      cycles_q <= 4'h0;
    end else begin
      // strobes last one cycle
      done_q <= 1'b0;
      ovf_set_q <= 1'b0;
      a_we_q <= 1'b0;
      b_we_q <= 1'b0;
      x_we_q <= 1'b0;
      refused_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          busy_q <= 1'b0;
          if (start && (one_mul || one_div)) begin
            // one-word form: low 12 bits address the operand
            a_q <= a_in;
            b_q <= b_in;
            x_q <= x_in;
            grp_q <= 1'b1;
            sub_q <= one_mul ? `MDX_G1_MUL : `MDX_G1_DIV;
            imm_q <= 1'b0;
            cycles_q <= cyc_dec;
            mem_addr_q <= {3'h0, instr[11:0]};
            mem_req_q <= 1'b1;
            busy_q <= 1'b1;
            state_q <= S_OPRD;
          end else if (start && ext_hit && dma_inhibit) begin
            refused_q <= 1'b1;
          end else if (start && ext_hit) begin
            a_q <= a_in;
            b_q <= b_in;
            x_q <= x_in;
            grp_q <= instr[6];
            sub_q <= instr[5:3];
            imm_q <= ea_imm;
            cycles_q <= cyc_dec;
            busy_q <= 1'b1;
            if (ea_imm) begin
              op_q <= word2;
              state_q <= S_EXEC;
            end else if (ea_ind) begin
              mem_addr_q <= word2[14:0];
              mem_req_q <= 1'b1;
              state_q <= S_IND;
            end else begin
              mem_addr_q <= ea;
              mem_req_q <= 1'b1;
              mem_we_q <= st_dec;
              mem_wdata_q <= (instr[5:3] == `MDX_G0_STB) ? b_in :
                             (instr[5:3] == `MDX_G0_STX) ? x_in : a_in;
              state_q <= st_dec ? S_WR : S_OPRD;
            end
          end
        end
        S_IND: begin
          // follow while bit 15 set, only reset escapes
          if (mem_ack) begin
            mem_addr_q <= mem_rdata[14:0];
            if (!mem_rdata[`MDX_SIGN]) begin
              mem_we_q <= ~grp_q & (sub_q >= `MDX_G0_STA);
              mem_wdata_q <= st_data;
              state_q <= (~grp_q & (sub_q >= `MDX_G0_STA)) ? S_WR : S_OPRD;
            end
          end
        end
        S_OPRD: begin
          // operand read completes on ack
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            op_q <= mem_rdata;
            state_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_q <= S_IDLE;
          done_q <= 1'b1;
          if (!grp_q) begin
            case (sub_q)
              `MDX_G0_LDA: begin
                a_q <= op_q;
                a_we_q <= 1'b1;
              end
              `MDX_G0_LDB: begin
                b_q <= op_q;
                b_we_q <= 1'b1;
              end
              `MDX_G0_LDX: begin
                x_q <= op_q;
                x_we_q <= 1'b1;
              end
              `MDX_G0_INR: begin
                if (!imm_q) begin
                  mem_wdata_q <= op_q + 16'h0001;
                  mem_we_q <= 1'b1;
                  mem_req_q <= 1'b1;
                  done_q <= 1'b0;
                  state_q <= S_WR;
                end
              end
              // immediate stores have no target
              default: done_q <= 1'b1;
            endcase
          end else begin
            case (sub_q)
              `MDX_G1_OR: a_q <= a_q | op_q;
              `MDX_G1_XOR: a_q <= a_q ^ op_q;
              `MDX_G1_AND: a_q <= a_q & op_q;
              `MDX_G1_ADD: begin
                a_q <= sum_w;
                ovf_set_q <= add_ovf;
              end
              `MDX_G1_SUB: begin
                a_q <= dif_w;
                ovf_set_q <= sub_ovf;
              end
              `MDX_G1_MUL: begin
                // start from A, multiplicand is the operand word
                prod_q <= {{16{a_q[15]}}, a_q};
                mcand_q <= {{16{op_q[15]}}, op_q};
                mplier_q <= b_q;
                cnt_q <= 5'h00;
                negative_operand_flag <= b_q[`MDX_SIGN];
                mul_ovf_q <= (b_q == `MDX_MOST_NEG) && (op_q == `MDX_MOST_NEG);
                done_q <= 1'b0;
                state_q <= S_MUL;
              end
              default: begin
                if (op_q == 16'h0000) begin
                  b_q <= ~a_q;
                  a_q <= {a_q[`MDX_SIGN], b_q[14:0]};
                  b_we_q <= 1'b1;
                  a_we_q <= 1'b1;
                  ovf_set_q <= 1'b1;
                end else begin
                  // A sign, B bit 15 dropped
                  dvd_q <= a_q[`MDX_SIGN] ? 31'h00000000 - dvd_raw : dvd_raw;
                  rm_q <= op_q[15] ? 17'h00000 - op_ext : op_ext;
                  rem_q <= 16'h0000;
                  cnt_q <= 5'h00;
                  negative_operand_flag <= a_q[`MDX_SIGN];
                  qneg_q <= a_q[`MDX_SIGN] ^ op_q[15];
                  done_q <= 1'b0;
                  state_q <= S_DIV;
                end
              end
            endcase
            if (sub_q <= `MDX_G1_AND) begin
              a_we_q <= 1'b1;
            end
          end
        end
        S_MUL: begin
          if (!last_cycle_flag) begin
            // add when lsb set, always shift
            if (add_step_flag) begin
              prod_q <= prod_q + mcand_q;
            end
            mcand_q <= {mcand_q[30:0], 1'b0};
            mplier_q <= {1'b0, mplier_q[15:1]};
            cnt_q <= cnt_q + 5'h01;
          end else begin
            // sign into A, B bit 15 cleared
            if (negative_operand_flag) begin
              a_q <= dif_hi(prod_q, mcand_q);
              b_q <= {1'b0, prod_q[14:0]};
            end else begin
              a_q <= prod_q[30:15];
              b_q <= {1'b0, prod_q[14:0]};
            end
            // overflow only for the one case
            ovf_set_q <= mul_ovf_q;
            a_we_q <= 1'b1;
            b_we_q <= 1'b1;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_DIV: begin
          // restoring step on magnitudes
          rem_q <= div_fit ? div_sub[15:0] : div_shift[15:0];
          dvd_q <= {dvd_q[29:0], div_fit};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == `MDX_DIV_LAST) begin
            state_q <= S_DFIN;
          end
        end
        S_DFIN: begin
          // quotient to B, remainder to A
          b_q <= q_fin;
          a_q <= r_fin;
          a_we_q <= 1'b1;
          b_we_q <= 1'b1;
          ovf_set_q <= q_ovf;
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        S_WR: begin
          // write completes on ack
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // high half after the correction subtract; low half is untouched
  // because the subtracted multiplicand sits at bit 15 and up
  function [15:0] dif_hi;
    input [31:0] p;
    input [31:0] m;
    reg [31:0] d;
    begin
      d = p - m;
      dif_hi = d[30:15];
    end
  endfunction
endmodule // mdx_core

/* mdx_core_checker.sv */
// Purpose: port-level checks on the multiply/divide and far address card
// Assumes: one clock, async active-high reset
// Notes: operands are snapshotted at start so results can be judged
module mdx_core_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic [15:0] instr,
  input wire logic [15:0] word2,
  input wire logic dma_inhibit,
  input wire logic [15:0] a_in,
  input wire logic [15:0] b_in,
  input wire logic [15:0] x_in,
  input wire logic [15:0] p_in,
  // memory
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic [14:0] mem_addr_q,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // results
  input wire logic [15:0] a_q,
  input wire logic [15:0] b_q,
  input wire logic ovf_set_q,
  input wire logic done_q,
  input wire logic refused_q,
  input wire logic busy_q,
  input wire logic [3:0] cycles_q
);
  logic [15:0] i_s, w_s, a_s, b_s, x_s, p_s, rd_s; // start snapshots and last read word
  wire go = start && !busy_q; // accepted start
  wire far_in = instr[15:7] == 9'h018; // 030h or 031h group
  wire far_s = i_s[15:7] == 9'h018;
  wire mul_s = i_s[15:12] == 4'hE || i_s[15:3] == 13'h018E;
  wire div_s = i_s[15:12] == 4'hF || i_s[15:3] == 13'h018F;
  // immediate far forms carry the operand in word two
  wire [15:0] r_s = (far_s && !i_s[2]) ? w_s : rd_s;
  // expected multiply result, A plus B times R
  wire signed [31:0] mp = $signed(a_s) + $signed(b_s) * $signed(r_s);
  // documented count per opcode class
  function automatic logic [3:0] cyc(input logic [15:0] i);
    if (i[15:13] == 3'h7) cyc = 4'hA;
    else if (i[15:4] == 12'h0C7) cyc = 4'hB;
    else if (i[15:3] == 13'h0184) cyc = 4'h4;
    else cyc = 4'h3;
  endfunction
  // snapshots; last read word is the operand
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {i_s, w_s, a_s, b_s, x_s, p_s, rd_s} <= '0;
    end else begin
      if (go) begin
        {i_s, w_s, a_s, b_s, x_s, p_s} <= {instr, word2, a_in, b_in, x_in, p_in};
      end
      if (mem_ack && mem_req_q && !mem_we_q) begin
        rd_s <= mem_rdata;
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  mul_sign_a: assert property (done_q && mul_s |-> a_q == mp[30:15] && b_q == {1'b0, mp[14:0]})
    else $error("multiply left B sign set");
  mul_ovf_a: assert property (done_q && mul_s |-> ovf_set_q == (r_s == 16'h8000 && b_s == 16'h8000))
    else $error("multiply overflow flag wrong");
  mul_time_a: assert property (mem_ack && busy_q && i_s[15:12] == 4'hE |-> !done_q [*8] ##11 done_q)
    else $error("one-word multiply finish time wrong");
  div_zero_a: assert property (done_q && div_s && r_s == 16'h0 |-> ovf_set_q && b_q == ~a_s
    && a_q == {a_s[15], b_s[14:0]})
    else $error("zero divisor result wrong");
  cycle_count_a: assert property ($rose(busy_q) |-> cycles_q == cyc(i_s))
    else $error("machine cycle count wrong");
  dma_refuse_a: assert property (go && far_in && dma_inhibit |=> refused_q && !busy_q)
    else $error("far form not refused under inhibit");
  imm_nomem_a: assert property (go && far_in && !dma_inhibit && !instr[2] && instr[5:3] != 3'h0
    && instr[15:4] != 12'h0C7 |=> !mem_req_q ##1 (done_q && !mem_req_q))
    else $error("immediate form touched memory");
  rel_addr_a: assert property ($rose(mem_req_q) && far_s && i_s[2:0] == 3'h4
    |-> mem_addr_q == w_s[14:0] + p_s[14:0] + 15'h1)
    else $error("relative address wrong");
  idx_addr_a: assert property ($rose(mem_req_q) && far_s && i_s[2] && (i_s[1] ^ i_s[0])
    |-> mem_addr_q == w_s[14:0] + (i_s[1] ? b_s[14:0] : x_s[14:0]))
    else $error("indexed address wrong");
endmodule // mdx_core_checker
bind mdx_core mdx_core_checker u_mdx_core_checker (.clk(clk), .rst(rst), .start(start), .instr(instr),
  .word2(word2), .dma_inhibit(dma_inhibit), .a_in(a_in), .b_in(b_in), .x_in(x_in), .p_in(p_in),
  .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .a_q(a_q), .b_q(b_q), .ovf_set_q(ovf_set_q), .done_q(done_q),
  .refused_q(refused_q), .busy_q(busy_q), .cycles_q(cycles_q));

/* mdx_mem.sv */
// Purpose: host memory-cycle model answering the card's requests
// Assumes: one access at a time, ack is a one-cycle pulse
// Notes: wait_n stretches the answer to mimic slow memory
module mdx_mem (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the card
  input wire logic req,
  input wire logic we,
  input wire logic [14:0] addr,
  input wire logic [15:0] wdata,
  // answer
  output logic ack,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:32767]; // whole 15-bit space
  int wait_n = 0; // extra cycles before ack
  int cnt = 0; // cycles waited so far
  initial ack = 1'b0;
  initial rdata = 16'h0000;
  // answer on the falling edge so the card samples a settled ack
  always @(negedge clk) begin
    if (ack || rst) begin
      ack <= 1'b0;
      cnt <= 0;
      // released data does not keep the old word
      rdata <= ~rdata;
    end else if (req) begin
      if (cnt >= wait_n) begin
        ack <= 1'b1;
        if (we) mem[addr] <= wdata;
        else rdata <= mem[addr];
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // mdx_mem

/* mdx_core_bench.sv */
// Purpose: self-checking bench for the card
// Assumes: inputs change on the falling edge
// Notes: expected values are worked out here from operands
module mdx_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, start = 0, dma_inhibit = 0;
  logic [15:0] instr = 0, word2 = 0, a_in = 0, b_in = 0, x_in = 16'h0010, p_in = 16'h0100;
  wire mem_req_q, mem_we_q, mem_ack, a_we_q, b_we_q, x_we_q, ovf_set_q, done_q, refused_q, busy_q;
  wire [14:0] mem_addr_q;
  wire [15:0] mem_wdata_q, mem_rdata, a_q, b_q, x_q;
  wire [3:0] cycles_q;
  int miscompares = 0, compares = 0;
  always #10 clk = ~clk;
  mdx_core u_mdx_core (.clk(clk), .rst(rst), .start(start), .instr(instr), .word2(word2),
    .dma_inhibit(dma_inhibit), .a_in(a_in), .b_in(b_in), .x_in(x_in), .p_in(p_in),
    .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .a_q(a_q), .b_q(b_q), .x_q(x_q), .a_we_q(a_we_q),
    .b_we_q(b_we_q), .x_we_q(x_we_q), .ovf_set_q(ovf_set_q), .done_q(done_q),
    .refused_q(refused_q), .busy_q(busy_q), .cycles_q(cycles_q));
  mdx_mem u_mdx_mem (.clk(clk), .rst(rst), .req(mem_req_q), .we(mem_we_q), .addr(mem_addr_q),
    .wdata(mem_wdata_q), .ack(mem_ack), .rdata(mem_rdata));
  // one compare for every result word
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one start, then wait bounded for done or refusal
  task automatic run(input logic [15:0] i, input logic [15:0] w, input logic [15:0] a,
    input logic [15:0] b, input logic e);
    int n;
    n = 0;
    @(negedge clk);
    {instr, word2, a_in, b_in, start} = {i, w, a, b, 1'b1};
    @(negedge clk);
    start = 1'b0;
    while (done_q !== 1'b1 && refused_q !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, done_q | refused_q}, {15'h0, e});
  endtask
  // multiply, one-word and far forms alternating
  task automatic t_mul;
    logic [15:0] tv [4][3];
    logic signed [31:0] p;
    tv = '{'{16'h0000, 16'hFFC8, 16'h04BC}, '{16'h0000, 16'h7FFF, 16'h7FFF},
      '{16'h0000, 16'h8000, 16'h8000}, '{16'h0005, 16'hFFFF, 16'h0001}};
    for (int k = 0; k < 4; k++) begin
      u_mdx_mem.mem[15'h12] = tv[k][2];
      run(k[0] ? 16'h0C77 : 16'hE012, 16'h0012, tv[k][0], tv[k][1], 1'b1);
      p = $signed({{16{tv[k][0][15]}}, tv[k][0]}) + $signed(tv[k][1]) * $signed(tv[k][2]);
      chk(a_q, p[30:15]);
      chk(b_q, {1'b0, p[14:0]});
      chk({15'h0, ovf_set_q}, {15'h0, tv[k][1] == 16'h8000 && tv[k][2] == 16'h8000});
    end
    $display("t_mul finished");
  endtask
  // divide with slow memory, special cases included
  task automatic t_div;
    logic [15:0] tv [5][3];
    logic signed [30:0] d31;
    int d, r, q, m;
    logic [15:0] ea, eb;
    logic eo;
    tv = '{'{16'hFFFF, 16'h7B2E, 16'h0268}, '{16'hFFFF, 16'h7FF8, 16'h0002},
      '{16'hFFFF, 16'h7FF8, 16'hFFFE}, '{16'h1234, 16'h0005, 16'h0000}, '{16'h4000, 16'h0000, 16'h0001}};
    u_mdx_mem.wait_n = 3;
    for (int k = 0; k < 5; k++) begin
      u_mdx_mem.mem[15'h12] = tv[k][2];
      run(k[0] ? 16'h0C7F : 16'hF012, 16'h0012, tv[k][0], tv[k][1], 1'b1);
      d31 = {tv[k][0], tv[k][1][14:0]};
      d = d31;
      r = $signed(tv[k][2]);
      eo = 1'b1;
      eb = ~tv[k][0];
      ea = {tv[k][0][15], tv[k][1][14:0]};
      if (r != 0) begin
        q = d / r;
        m = d % r;
        // exact negative multiple keeps a full divisor as remainder
        if (d < 0 && m == 0) begin
          q = (q < 0) ? q + 1 : q - 1;
          m = (r < 0) ? r : -r;
        end
        eo = q > 32767 || q < -32768;
        eb = q[15:0];
        ea = m[15:0];
      end
      chk({15'h0, ovf_set_q}, {15'h0, eo});
      chk({15'h0, b_we_q}, 16'h0001);
      if (!eo || r == 0) begin
        chk(b_q, eb);
        chk(a_q, ea);
      end
    end
    u_mdx_mem.wait_n = 0;
    $display("t_div finished");
  endtask
  // far load in every mode, indirect chain, store, bump, arithmetic
  task automatic t_far;
    logic [15:0] ea, ex;
    for (int m = 0; m < 8; m++) begin
      ea = (m == 4) ? 16'h0301 : (m == 5) ? 16'h0210 : (m == 6) ? 16'h0220 : 16'h0200;
      u_mdx_mem.mem[ea[14:0]] = ea ^ 16'h5A5A;
      run({10'h030, 3'h1, m[2:0]}, 16'h0200, 16'h0000, 16'h0020, 1'b1);
      chk(a_q, (m < 4) ? 16'h0200 : ea ^ 16'h5A5A);
    end
    u_mdx_mem.mem[15'h400] = 16'h8401;
    u_mdx_mem.mem[15'h401] = 16'h0402;
    u_mdx_mem.mem[15'h402] = 16'h1357;
    run(16'h0C4F, 16'h8400, 16'h0000, 16'h0000, 1'b1);
    chk(a_q, 16'h1357);
    run(16'h0C18, 16'h1234, 16'h0000, 16'h0000, 1'b1);
    chk(x_q, 16'h1234);
    chk({15'h0, x_we_q}, 16'h0001);
    run(16'h0C35, 16'h0300, 16'h0000, 16'hBEEF, 1'b1);
    chk(u_mdx_mem.mem[15'h310], 16'hBEEF);
    u_mdx_mem.mem[15'h320] = 16'h7FFF;
    run(16'h0C26, 16'h0300, 16'h0000, 16'h0020, 1'b1);
    chk(u_mdx_mem.mem[15'h320], 16'h8000);
    u_mdx_mem.mem[15'h500] = 16'h00F3;
    for (int k = 1; k < 6; k++) begin
      run({10'h031, k[2:0], 3'h7}, 16'h0500, 16'h0F35, 16'h0000, 1'b1);
      ex = (k == 1) ? 16'h0FF7 : (k == 2) ? 16'h1028 : (k == 3) ? 16'h0FC6 : (k == 4) ? 16'h0E42 : 16'h0031;
      chk(a_q, ex);
      chk({15'h0, a_we_q}, 16'h0001);
    end
    $display("t_far finished");
  endtask
  // inhibit refuses far forms, then a circular chain only reset ends
  task automatic t_refuse_loop;
    dma_inhibit = 1'b1;
    run(16'h0C48, 16'h0200, 16'h0000, 16'h0000, 1'b1);
    chk({15'h0, done_q}, 16'h0000);
    dma_inhibit = 1'b0;
    u_mdx_mem.mem[15'h600] = 16'h8601;
    u_mdx_mem.mem[15'h601] = 16'h8600;
    run(16'h0C4F, 16'h8600, 16'h0000, 16'h0000, 1'b0);
    chk({15'h0, busy_q}, 16'h0001);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({15'h0, busy_q | mem_req_q}, 16'h0000);
    $display("t_refuse_loop finished");
  endtask
  task automatic end_sim;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, well past the expected several hundred cycles
  initial begin
    #1000000;
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_mul;
    t_div;
    t_far;
    t_refuse_loop;
    end_sim;
  end
endmodule // mdx_core_bench
